// ### hw/timer_ctl.sv
// Timer width, mode and control registers with capture edge and output gating
`include "timer_ctl_regs.svh"

module timer_ctl (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	// Register bus
	input  wire timer_ctl_pkg::axil_req_t axil_req_i,
	output      timer_ctl_pkg::axil_rsp_t axil_rsp_o,
	// Processor debug state
	input  wire logic                     dbg_halt_i,
	// Capture pins
	input  wire logic                     ccp_a_i,
	input  wire logic                     ccp_b_i,
	// Half A raw outputs from the counter core
	input  wire logic                     pwm_a_raw_i,
	input  wire logic                     trig_a_raw_i,
	// Mode and enables toward the counter core
	output      timer_ctl_pkg::mode_t     half_a_mode_o,
	output      timer_ctl_pkg::mode_t     half_b_mode_o,
	output      logic                     split_16bit_o,
	output      logic                     rtc_count_en_o,
	output      logic                     half_a_count_en_o,
	output      logic                     half_b_count_en_o,
	// Capture events and gated outputs
	output      logic                     cap_a_evt_o,
	output      logic                     cap_b_evt_o,
	output      logic                     pwm_a_o,
	output      logic                     adc_trig_o
);
	import timer_ctl_pkg::*;

	state_t s_reg;
	state_t s_next;
	mode_t  a_mode;
	mode_t  b_mode;
	logic   a_frozen;
	logic   b_frozen;
	logic   a_armed;
	logic   b_armed;
	logic   wr_fire;
	logic   wr_hit;
	logic   rd_hit;

	// Two-bit mode field to mode, code 00 means no mode
	function automatic mode_t dec_mode(input logic [1:0] f);
		dec_mode = MODE_NONE;
		unique case (f)
			2'b01: dec_mode = MODE_ONE_SHOT;
			2'b10: dec_mode = MODE_PERIODIC;
			2'b11: dec_mode = MODE_CAPTURE;
			2'b00: dec_mode = MODE_NONE;
		endcase
	endfunction : dec_mode

	// Selected edge between previous and current synchronised level
	function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
					  input logic prev);
		edge_hit = 1'b0;
		unique case (sel)
			2'b00: edge_hit = cur & ~prev;
			2'b01: edge_hit = ~cur & prev;
			2'b11: edge_hit = cur ^ prev;
			2'b10: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
					       input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : merge

	// Address is one of the writable registers
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `TC_OFF_WIDTH) || (a == `TC_OFF_A_MODE) ||
			 (a == `TC_OFF_B_MODE) || (a == `TC_OFF_CONTROL);
	endfunction : mapped

	// Effective modes from width configuration
	always_comb begin
		split_16bit_o = s_reg.cfg[`TC_CFG_16BIT];
		a_mode        = dec_mode(s_reg.amode[1:0]);
		b_mode        = split_16bit_o ? dec_mode(s_reg.bmode[1:0]) : a_mode;
		half_a_mode_o = a_mode;
		half_b_mode_o = b_mode;
	end

	// Run and debug freeze per half
	// Freeze needs the stall bit and a halted core, so a running core ignores it
	always_comb begin
		a_frozen          = s_reg.ctl[`TC_A_STALL] & dbg_halt_i;
		b_frozen          = s_reg.ctl[`TC_B_STALL] & dbg_halt_i;
		half_a_count_en_o = s_reg.ctl[`TC_A_RUN] & ~a_frozen;
		half_b_count_en_o = s_reg.ctl[`TC_B_RUN] & ~b_frozen;
		a_armed           = half_a_count_en_o & (a_mode == MODE_CAPTURE);
		b_armed           = half_b_count_en_o & (b_mode == MODE_CAPTURE);
		rtc_count_en_o    = s_reg.ctl[`TC_RTC_EN];
	end

	// Registered outputs
	always_comb begin
		cap_a_evt_o = s_reg.evt_a;
		cap_b_evt_o = s_reg.evt_b;
		pwm_a_o     = s_reg.pwm;
		adc_trig_o  = s_reg.trig;
	end

	// Bus handshakes from state
	// Readiness drops once a channel is held, so a second request waits for the answer
	always_comb begin
		wr_fire            = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
		wr_hit             = mapped(s_reg.waddr);
		rd_hit             = mapped(axil_req_i.araddr) || (axil_req_i.araddr == `TC_OFF_STATUS);
		axil_rsp_o.awready = ~s_reg.aw_got & ~s_reg.bvalid;
		axil_rsp_o.wready  = ~s_reg.w_got & ~s_reg.bvalid;
		axil_rsp_o.bvalid  = s_reg.bvalid;
		axil_rsp_o.bresp   = s_reg.bresp;
		axil_rsp_o.arready = ~s_reg.rvalid;
		axil_rsp_o.rvalid  = s_reg.rvalid;
		axil_rsp_o.rdata   = s_reg.rdata;
		axil_rsp_o.rresp   = s_reg.rresp;
	end

	// Next state: bus slave, registers, synchronisers and gated outputs
	always_comb begin
		logic [31:0] w;
		w      = 32'h0000_0000;
		s_next = s_reg;
		// Write address and data taken in either order
		if (axil_req_i.awvalid && axil_rsp_o.awready) begin
			s_next.aw_got = 1'b1;
			s_next.waddr  = axil_req_i.awaddr;
		end
		if (axil_req_i.wvalid && axil_rsp_o.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = axil_req_i.wdata;
			s_next.wstrb = axil_req_i.wstrb;
		end
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got  = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp  = wr_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
			unique case (s_reg.waddr)
				`TC_OFF_WIDTH: begin
					w           = merge({29'h0, s_reg.cfg}, s_reg.wdata, s_reg.wstrb);
					s_next.cfg  = w[2:0];
				end
				`TC_OFF_A_MODE: begin
					w            = merge({28'h0, s_reg.amode}, s_reg.wdata, s_reg.wstrb);
					s_next.amode = w[3:0];
				end
				`TC_OFF_B_MODE: begin
					w            = merge({28'h0, s_reg.bmode}, s_reg.wdata, s_reg.wstrb);
					s_next.bmode = w[3:0];
				end
				`TC_OFF_CONTROL: begin
					w                   = merge({20'h0, s_reg.ctl}, s_reg.wdata,
								    s_reg.wstrb);
					s_next.ctl          = w[11:0];
					s_next.ctl[`TC_RSVD7] = 1'b0;
				end
				default: begin
					w = 32'h0000_0000;
				end
			endcase
		end
		if (s_reg.bvalid && axil_req_i.bready) begin
			s_next.bvalid = 1'b0;
		end
		// Read channel, one word per request
		if (s_reg.rvalid && axil_req_i.rready) begin
			s_next.rvalid = 1'b0;
		end
		if (axil_req_i.arvalid && axil_rsp_o.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = rd_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
			s_next.rd_ctl = (axil_req_i.araddr == `TC_OFF_CONTROL);
			unique case (axil_req_i.araddr)
				`TC_OFF_WIDTH:   s_next.rdata = {29'h0, s_reg.cfg};
				`TC_OFF_A_MODE:  s_next.rdata = {28'h0, s_reg.amode};
				`TC_OFF_B_MODE:  s_next.rdata = {28'h0, s_reg.bmode};
				`TC_OFF_CONTROL: s_next.rdata = {20'h0, s_reg.ctl};
				`TC_OFF_STATUS:  s_next.rdata = {24'h0, dbg_halt_i,
								 half_b_count_en_o, half_a_count_en_o,
								 split_16bit_o, b_mode, a_mode};
				default:         s_next.rdata = 32'h0000_0000;
			endcase
		end
		// Pin synchronisers, second stage feeds edge history
		// First stage may settle late, so only the second stage is ever read
		s_next.sync_a = {s_reg.sync_a[0], ccp_a_i};
		s_next.sync_b = {s_reg.sync_b[0], ccp_b_i};
		s_next.prev_a = s_reg.sync_a[1];
		s_next.prev_b = s_reg.sync_b[1];
		// One event per chosen edge while armed and not frozen
		s_next.evt_a = a_armed & edge_hit(s_reg.ctl[`TC_A_EDGE_HI:`TC_A_EDGE_LO],
						   s_reg.sync_a[1], s_reg.prev_a);
		s_next.evt_b = b_armed & edge_hit(s_reg.ctl[`TC_B_EDGE_HI:`TC_B_EDGE_LO],
						   s_reg.sync_b[1], s_reg.prev_b);
		// Half A output shaping
		s_next.pwm  = pwm_a_raw_i ^ s_reg.ctl[`TC_A_PWM_INV];
		s_next.trig = trig_a_raw_i & s_reg.ctl[`TC_A_TRIG_EN];
	end

	// State register
	// Synchronous reset clears everything, then fields take their reset values
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s_reg       <= '0;
			s_reg.cfg   <= `TC_RST_WIDTH;
			s_reg.amode <= `TC_RST_MODE;
			s_reg.bmode <= `TC_RST_MODE;
			s_reg.ctl   <= `TC_RST_CONTROL;
		end else begin
			s_reg <= s_next;
		end
	end

	// Checks on decode, gating and capture timing
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence b_rise_armed;
		($rose(ccp_b_i) && b_armed && s_reg.ctl[11:10] == 2'b00)
			##1 (b_armed && s_reg.ctl[11:10] == 2'b00)[*2];
	endsequence

	sequence b_edge_reserved;
		(s_reg.ctl[11:10] == 2'b10)[*3];
	endsequence

	sequence a_rise_armed;
		($rose(ccp_a_i) && a_armed && s_reg.ctl[3:2] == 2'b00)
			##1 (a_armed && s_reg.ctl[3:2] == 2'b00)[*2];
	endsequence

	sequence b_fall_armed;
		($fell(ccp_b_i) && b_armed && s_reg.ctl[11:10] == 2'b01)
			##1 (b_armed && s_reg.ctl[11:10] == 2'b01)[*2];
	endsequence

	sequence a_both_armed;
		($changed(ccp_a_i) && a_armed && s_reg.ctl[3:2] == 2'b11)
			##1 (a_armed && s_reg.ctl[3:2] == 2'b11)[*2];
	endsequence

	sequence a_edge_reserved;
		(s_reg.ctl[3:2] == 2'b10)[*3];
	endsequence

	b_mode_dec_a: assert property (split_16bit_o && s_reg.bmode[1:0] == 2'b11
		|-> half_b_mode_o == MODE_CAPTURE) else $error("half B capture decode wrong");
	b_split_mode_a: assert property (split_16bit_o && s_reg.bmode[1:0] == 2'b00
		|-> half_b_mode_o == MODE_NONE) else $error("half B split mode wrong");
	b_wide_mode_a: assert property (!split_16bit_o
		|-> half_b_mode_o == half_a_mode_o) else $error("32-bit mode not from half A");
	b_rise_evt_a: assert property (b_rise_armed |=> cap_b_evt_o)
		else $error("half B rising edge missed");
	b_freeze_a: assert property (dbg_halt_i && s_reg.ctl[9]
		|-> !half_b_count_en_o) else $error("half B counts while halted");
	b_no_halt_a: assert property (!dbg_halt_i && s_reg.ctl[8]
		|-> half_b_count_en_o) else $error("freeze acts without halt");
	b_run_off_a: assert property ($fell(s_reg.ctl[8])
		|-> !half_b_count_en_o ##1 !cap_b_evt_o) else $error("half B runs disabled");
	pwm_invert_a: assert property (pwm_a_o == $past(pwm_a_raw_i ^ s_reg.ctl[6]))
		else $error("PWM level wrong");
	trig_gate_a: assert property (adc_trig_o |-> $past(trig_a_raw_i && s_reg.ctl[5]))
		else $error("ADC trigger not gated");
	rsvd_read_a: assert property (axil_rsp_o.rvalid && s_reg.rd_ctl
		|-> !axil_rsp_o.rdata[7]) else $error("reserved bit reads one");
	a_freeze_a: assert property (dbg_halt_i && s_reg.ctl[1]
		|-> !half_a_count_en_o) else $error("half A counts while halted");
	b_rsvd_edge_a: assert property (b_edge_reserved |-> !cap_b_evt_o)
		else $error("reserved edge gave event");
	evt_pulse_a: assert property (cap_a_evt_o |-> $past(s_reg.sync_a[1]) != $past(s_reg.prev_a))
		else $error("half A event without edge");
	wr_resp_a: assert property ($rose(axil_rsp_o.bvalid) |-> $past(s_reg.aw_got && s_reg.w_got))
		else $error("write answered early");

	// Capture edges of each coding and single-cycle pulses
	a_rise_evt_a: assert property (a_rise_armed |=> cap_a_evt_o)
		else $error("half A rising edge missed");
	b_fall_evt_a: assert property (b_fall_armed |=> cap_b_evt_o)
		else $error("half B falling edge missed");
	a_both_evt_a: assert property (a_both_armed |=> cap_a_evt_o)
		else $error("half A edge missed in both-edge coding");
	a_rsvd_edge_a: assert property (a_edge_reserved |-> !cap_a_evt_o)
		else $error("half A reserved edge gave event");
	evt_single_a: assert property (cap_b_evt_o && s_reg.ctl[11:10] != 2'b11
		&& $stable(s_reg.ctl[11:10]) |=> !cap_b_evt_o) else $error("half B event too long");

	// Mode decode, enables and output gating
	b_one_shot_a: assert property (split_16bit_o && s_reg.bmode[1:0] == 2'b01
		|-> half_b_mode_o == MODE_ONE_SHOT) else $error("half B one-shot decode wrong");
	b_run_on_a: assert property (s_reg.ctl[8] && !(dbg_halt_i && s_reg.ctl[9])
		|-> half_b_count_en_o) else $error("half B not running");
	a_run_a: assert property (!dbg_halt_i
		|-> half_a_count_en_o == s_reg.ctl[0]) else $error("half A run bit ignored");
	trig_pass_a: assert property (trig_a_raw_i && s_reg.ctl[5] |=> adc_trig_o)
		else $error("ADC trigger not passed");
	rtc_write_a: assert property (wr_fire && s_reg.waddr == `TC_OFF_CONTROL
		&& s_reg.wstrb[0] |=> rtc_count_en_o == $past(s_reg.wdata[4]))
		else $error("RTC enable not written");
	rsvd_write_a: assert property (wr_fire && s_reg.waddr == `TC_OFF_CONTROL
		|=> !s_reg.ctl[7]) else $error("reserved bit stored");

	// Register bus answers
	rd_answer_a: assert property (axil_req_i.arvalid && axil_rsp_o.arready
		|=> axil_rsp_o.rvalid) else $error("read not answered next cycle");
	rd_refuse_a: assert property (axil_req_i.arvalid && axil_rsp_o.arready && !rd_hit
		|=> axil_rsp_o.rresp == `TC_RESP_SLVERR && axil_rsp_o.rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	amode_write_a: assert property (wr_fire && s_reg.waddr == `TC_OFF_A_MODE && s_reg.wstrb[0]
		|=> s_reg.amode == $past(s_reg.wdata[3:0])) else $error("mode write lost");
	wr_refuse_a: assert property (axil_rsp_o.bvalid
		|-> !axil_rsp_o.awready && !axil_rsp_o.wready) else $error("write taken before answer");

endmodule : timer_ctl

// ### hw/timer_ctl_pkg.sv
// Types shared by the timer control slice
package timer_ctl_pkg;
	typedef enum logic [1:0] {
		MODE_NONE     = 2'b00,
		MODE_ONE_SHOT = 2'b01,
		MODE_PERIODIC = 2'b10,
		MODE_CAPTURE  = 2'b11
	} mode_t;
	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} axil_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;
	typedef struct packed {
		logic [2:0]  cfg;
		logic [3:0]  amode;
		logic [3:0]  bmode;
		logic [11:0] ctl;
		logic        aw_got;
		logic        w_got;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rd_ctl;
		logic [1:0]  sync_a;
		logic [1:0]  sync_b;
		logic        prev_a;
		logic        prev_b;
		logic        evt_a;
		logic        evt_b;
		logic        pwm;
		logic        trig;
	} state_t;
endpackage : timer_ctl_pkg

// ### hw/timer_ctl_regs.svh
// Register offsets, field positions, reset values and bus codes of the timer control slice
`ifndef TIMER_CTL_REGS_SVH
`define TIMER_CTL_REGS_SVH
`define TC_ADDR_W        12
`define TC_OFF_WIDTH     12'h000
`define TC_OFF_A_MODE    12'h004
`define TC_OFF_B_MODE    12'h008
`define TC_OFF_CONTROL   12'h00C
`define TC_OFF_STATUS    12'h010
`define TC_RST_WIDTH     3'h0
`define TC_RST_MODE      4'h0
`define TC_RST_CONTROL   12'h000
`define TC_WIDTH_BITS    3
`define TC_MODE_BITS     4
`define TC_CTL_BITS      12
`define TC_CFG_16BIT     2
`define TC_CFG_RTC       3'h1
`define TC_B_EDGE_HI     11
`define TC_B_EDGE_LO     10
`define TC_B_STALL       9
`define TC_B_RUN         8
`define TC_RSVD7         7
`define TC_A_PWM_INV     6
`define TC_A_TRIG_EN     5
`define TC_RTC_EN        4
`define TC_A_EDGE_HI     3
`define TC_A_EDGE_LO     2
`define TC_A_STALL       1
`define TC_A_RUN         0
`define TC_RESP_OKAY     2'h0
`define TC_RESP_SLVERR   2'h2
`endif

// ### tb/testbench.sv
// Self-checking bench for the timer control slice
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_ctl_pkg::*;
	logic        core_clk;
	logic        reset;
	axil_req_t   req;
	axil_rsp_t   rsp;
	logic        dbg_halt;
	logic        ccp_a;
	logic        ccp_b;
	logic        pwm_raw;
	logic        trig_raw;
	mode_t       a_mode;
	mode_t       b_mode;
	logic        split16;
	logic        rtc_en;
	logic        a_en;
	logic        b_en;
	logic        a_evt;
	logic        b_evt;
	logic        pwm_o;
	logic        trig_o;
	int          err_total;
	int          n_checks;
	logic [31:0] rd_val;
	logic [1:0]  resp;

	// Block under test
	timer_ctl uut (
		.core_clk_i       (core_clk),
		.reset_i          (reset),
		.axil_req_i       (req),
		.axil_rsp_o       (rsp),
		.dbg_halt_i       (dbg_halt),
		.ccp_a_i          (ccp_a),
		.ccp_b_i          (ccp_b),
		.pwm_a_raw_i      (pwm_raw),
		.trig_a_raw_i     (trig_raw),
		.half_a_mode_o    (a_mode),
		.half_b_mode_o    (b_mode),
		.split_16bit_o    (split16),
		.rtc_count_en_o   (rtc_en),
		.half_a_count_en_o(a_en),
		.half_b_count_en_o(b_en),
		.cap_a_evt_o      (a_evt),
		.cap_b_evt_o      (b_evt),
		.pwm_a_o          (pwm_o),
		.adc_trig_o       (trig_o)
	);

	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Verdict and end of run
	task automatic tally_and_finish;
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	// One comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// One clock with a bound on the wait
	task automatic tick(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 40) begin
			err_total++;
			$display("mismatch at %0t: bus timeout", $time);
			tally_and_finish();
		end
	endtask : tick

	// Write: address and data offered together, each released when taken
	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
			      input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		req.awaddr  <= a;
		req.awvalid <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= s;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		forever begin
			tick(n);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) break;
		end
		r = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge core_clk);
	endtask : bus_wr

	// Read: address held until taken, data taken with rvalid
	task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		forever begin
			tick(n);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) break;
		end
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge core_clk);
	endtask : bus_rd

	// Write expecting OKAY
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus_wr(a, d, resp);
		chk(resp, 2'h0, "write response");
	endtask : wr

	// Read expecting OKAY and a value
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
		bus_rd(a, rd_val, resp);
		chk(resp, 2'h0, "read response");
		chk(rd_val, exp, what);
	endtask : rdc

	// Let register updates reach the outputs
	task automatic step;
		repeat (2) @(posedge core_clk);
	endtask : step

	// Pulse both capture pins and count events per half
	task automatic cap_try(input logic [1:0] sel, input int want);
		int na;
		int nb;
		na = 0;
		nb = 0;
		wr(12'h00C, {20'h0, sel, 2'b01, 4'h0, sel, 2'b01});
		for (int c = 0; c < 16; c++) begin
			ccp_a <= (c >= 2 && c < 9);
			ccp_b <= (c >= 2 && c < 9);
			@(posedge core_clk);
			if (a_evt === 1'b1) na++;
			if (b_evt === 1'b1) nb++;
		end
		chk(na, want, "half A events");
		chk(nb, want, "half B events");
	endtask : cap_try

	// Main sequence
	initial begin
		err_total = 0;
		n_checks  = 0;
		req       = '0;
		reset     = 1'b1;
		dbg_halt  = 1'b0;
		ccp_a     = 1'b0;
		ccp_b     = 1'b0;
		pwm_raw   = 1'b0;
		trig_raw  = 1'b0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rdc(12'h00C, 32'h0, "control at reset");
		chk(b_mode, MODE_NONE, "B mode at reset");
		// Reserved bit and rtc enable
		wr(12'h00C, 32'hFFFF_FFFF);
		rdc(12'h00C, 32'h0000_0F7F, "control readback");
		chk(rtc_en, 1'b1, "rtc on");
		wr(12'h00C, 32'h0000_0F6F);
		step();
		chk(rtc_en, 1'b0, "rtc off");
		// Unmapped places
		bus_rd(12'h020, rd_val, resp);
		chk(resp, 2'h2, "unmapped read resp");
		chk(rd_val, 32'h0, "unmapped read data");
		bus_wr(12'h024, 32'hFFFF_FFFF, resp);
		chk(resp, 2'h2, "unmapped write resp");
		// Mode decode in split and whole configuration
		wr(12'h000, 32'h4);
		wr(12'h004, 32'h2);
		for (int m = 0; m < 4; m++) begin
			wr(12'h008, m);
			step();
			chk(b_mode, m, "B mode split");
			chk(a_mode, MODE_PERIODIC, "A mode split");
			chk(split16, 1'b1, "split flag");
		end
		rdc(12'h010, 32'h0000_007E, "status word");
		bus_wr(12'h010, 32'h0000_0000, resp);
		chk(resp, 2'h2, "status write resp");
		bus_wr(12'h00C, 32'h0000_0000, resp, 4'h2);
		chk(resp, 2'h0, "lane write resp");
		rdc(12'h00C, 32'h0000_006F, "byte-lane write");
		wr(12'h000, 32'h0);
		step();
		chk(b_mode, MODE_PERIODIC, "B mode whole");
		// Run and freeze against debug halt
		for (int i = 0; i < 8; i++) begin
			wr(12'h00C, {22'h0, i[1:0], 6'h0, i[1:0]});
			dbg_halt <= i[2];
			step();
			chk(a_en, i[0] && !(i[1] && i[2]), "A count enable");
			chk(b_en, i[0] && !(i[1] && i[2]), "B count enable");
		end
		dbg_halt <= 1'b0;
		// Output inversion and trigger gating
		wr(12'h00C, 32'h40);
		pwm_raw  <= 1'b1;
		trig_raw <= 1'b1;
		step();
		chk(pwm_o, 1'b0, "pwm inverted");
		chk(trig_o, 1'b0, "trigger blocked");
		wr(12'h00C, 32'h20);
		step();
		chk(pwm_o, 1'b1, "pwm straight");
		chk(trig_o, 1'b1, "trigger passed");
		// Capture edges in every coding
		wr(12'h000, 32'h4);
		wr(12'h004, 32'h3);
		wr(12'h008, 32'h3);
		cap_try(2'h0, 1);
		cap_try(2'h1, 1);
		cap_try(2'h2, 0);
		cap_try(2'h3, 2);
		tally_and_finish();
	end
endmodule : testbench
